/* File: bench/ahb_host.sv */
// Bus master standing in for the controller
`timescale 1ns/1ps
`default_nettype none
module ahb_host (
  // Clock
  input  wire logic        clk_sys,
  // Request
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  // Answer
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout
);
  // Idle bus from time zero
  initial begin
    {haddr, hwdata, htrans, hwrite} = '0;
    hsel = 1'b1;
    hsize = oc_ctrl_pkg::HSIZE_WORD;
  end
  // Wait for ready at a rising edge, bounded
  task automatic rdy(inout int n);
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
  endtask
  // One word transfer, address then data phase
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy(n);
    htrans <= 2'h0;
    hwdata <= d;
    rdy(n);
    r = hrdata;
    if (n >= 40) tb_top.hang();
  endtask
endmodule // ahb_host
`default_nettype wire

/* File: bench/oc_ctrl_sva.sv */
// Port checker for the overcurrent window control
`timescale 1ns/1ps
`default_nettype none
module oc_ctrl_sva (
  // Clock, reset and bus answer
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [1:0] htrans,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Analogue flags
  input wire logic       supply_low_flag,
  input wire logic       charge_pump_fail,
  input wire logic       die_temp_high,
  input wire logic [4:0] out_above_half,
  // Channel outputs
  input wire logic [4:0] channel_drive,
  input wire logic [9:0] window_stage,
  input wire logic [4:0] ssc_arm,
  input wire logic [4:0] ochi_halve,
  input wire logic       high_overcurrent_stage_one_derate
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Bus never stalls and always answers OKAY
  bus_okay_a: assert property (hresp == 1'b0) else $error("bus error");
  ready_held_a: assert property ($past(rst_n) |-> hreadyout)
    else $error("bus stalled");
  // Supply low drops every drive after the two sync stages
  uv_drive_off_a: assert property (
    supply_low_flag [*4] |-> channel_drive == 5'h00) else $error("no cut");
  // Channel zero window holds while its drive is low and the bus is quiet
  gate_hold_a: assert property (
    (!channel_drive[0] && htrans == 2'h0) [*6] |-> $stable(window_stage[1:0]))
    else $error("window ran while off");
  pump_hold_a: assert property (
    charge_pump_fail [*5] |-> $stable(window_stage)) else $error("pump run");
  ssc_armed_a: assert property (
    $rose(channel_drive[0]) |-> ##[0:1] ssc_arm[0]) else $error("not armed");
  cool_derate_a: assert property (
    !die_temp_high [*4] |-> !high_overcurrent_stage_one_derate) else $error("cool derate");
  above_halve_a: assert property (
    out_above_half[0] [*4] |-> !ochi_halve[0]) else $error("halved high");
endmodule // oc_ctrl_sva
`default_nettype wire

/* File: bench/tb_top.sv */
// Testbench for the overcurrent window control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Bus, clock and reset
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, w;
  // Flags, PWM and outputs
  logic supply_low_flag, charge_pump_fail, die_temp_high, high_overcurrent_stage_one_derate;
  logic [4:0] high_overcurrent_stage_one, high_overcurrent_stage_two;
  logic [4:0] high_overcurrent_stage_three, low_overcurrent, pwm_full;
  logic [4:0] overtemp_shutdown, severe_short_detect, open_load;
  logic [4:0] out_above_half, input_pin_toggle, pwm_level, ssc_arm;
  logic [4:0] channel_drive, low_oc_applied, low_threshold_low, ochi_halve;
  logic [9:0] window_stage;
  int         fails = 0, tests_run = 0, seed = 48231;
  // Clock and instances
  always #25 clk_sys = ~clk_sys;
  assign hready = hreadyout;
  overcurrent_window_control #(.WIN1_CYC(20), .WIN2_CYC(40), .WIN3_CYC(80),
    .RESTART_CYC(50)) overcurrent_window_control_i (.*);
  ahb_host ahb_host_i (.*);
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang;
    fails++;
    test_done();
  endtask
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, d);
    ahb_host_i.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [31:0] a, exp);
    ahb_host_i.xfer(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask
  // Bits that hold in each register word after CTRL
  function automatic logic [31:0] mask(input int i);
    return i == 1 ? 32'h0000_331F : i == 2 ? 32'h001F_1F1F : 32'h0000_0000;
  endfunction
  // Count cycles until channel zero reaches a window stage
  task automatic stage_in(input logic [1:0] s, input int lo, hi);
    int n;
    n = 0;
    while (window_stage[1:0] !== s && n <= hi) begin
      tick(1);
      n++;
    end
    if (n > hi) hang();
    chk(n >= lo, 1);
  endtask
  // Main sequence
  initial begin
    {supply_low_flag, charge_pump_fail, die_temp_high, pwm_full, pwm_level,
     high_overcurrent_stage_one, high_overcurrent_stage_two, open_load,
     high_overcurrent_stage_three, low_overcurrent, overtemp_shutdown,
     severe_short_detect, out_above_half, input_pin_toggle} = '0;
    tick(3);
    rst_n <= 1'b1;
    tick(2);
    for (int i = 0; i < 5; i++) begin
      rdc(4 * i, 32'h0000_0000);
      w = $random(seed);
      if (i > 0) wr(4 * i, w);
      if (i > 0) rdc(4 * i, w & mask(i));
      if (i == 2) chk(low_threshold_low, w[4:0]);
    end
    wr(4, 0);
    wr(8, 0);
    pwm_level <= 5'h01;
    wr(0, 1);
    tick(3);
    chk(window_stage[1:0], 1);
    stage_in(2, 14, 24);
    supply_low_flag <= 1'b1;
    tick(4);
    chk(channel_drive[0], 0);
    supply_low_flag <= 1'b0;
    wr(0, 1);
    tick(3);
    chk(channel_drive[0], 1);
    chk(window_stage[1:0], 2);
    wr(0, 0);
    wr(0, 1);
    tick(3);
    chk(window_stage[1:0], 1);
    pwm_level <= 5'h00;
    tick(40);
    chk(window_stage[1:0], 1);
    pwm_level <= 5'h01;
    stage_in(2, 12, 24);
    wr(8, 32'h0001_0000);
    tick(2);
    chk(window_stage[1:0], 0);
    chk(low_oc_applied[0], 1);
    wr(0, 0);
    wr(0, 1);
    tick(3);
    chk(window_stage[1:0], 0);
    wr(8, 32'h0000_0100);
    wr(0, 0);
    wr(0, 1);
    tick(3);
    stage_in(2, 4, 12);
    wr(4, 32'h0000_1000);
    die_temp_high <= 1'b1;
    charge_pump_fail <= 1'b1;
    tick(8);
    chk(high_overcurrent_stage_one_derate, 1);
    {die_temp_high, charge_pump_fail} <= 2'h0;
    repeat (16) begin
      {pwm_level, open_load, out_above_half, pwm_full} <= $random(seed);
      tick(1);
      chk(channel_drive[0], pwm_level[0]);
    end
    wr(4, 32'h0000_0001);
    high_overcurrent_stage_one <= 5'h01;
    tick(4);
    high_overcurrent_stage_one <= 5'h00;
    rdc(4, 32'h0000_0000);
    wr(4, 32'h0000_0000);
    wr(0, 32'h0000_0000);
    wr(0, 32'h0000_0100);
    input_pin_toggle <= 5'h02;
    tick(5);
    chk(channel_drive[1], 1);
    high_overcurrent_stage_two <= 5'h02;
    tick(4);
    high_overcurrent_stage_two <= 5'h00;
    chk(channel_drive[1], 0);
    tick(30);
    chk(channel_drive[1], 0);
    tick(34);
    chk(channel_drive[1], 1);
    overtemp_shutdown <= 5'h02;
    tick(4);
    overtemp_shutdown <= 5'h00;
    tick(70);
    chk(channel_drive[1], 0);
    test_done();
  end
endmodule // tb_top
bind overcurrent_window_control oc_ctrl_sva oc_ctrl_sva_i (.*);
`default_nettype wire

/* File: logic/oc_ctrl_pkg.sv */
// Constants, types and register map for the overcurrent window control
package oc_ctrl_pkg;

  localparam int NUM_CH = 5;
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  // Nominal times as printed
  localparam int T_WIN1_US = 2000;
  localparam int T_WIN2_US = 8000;
  localparam int T_WIN3_US = 64000;
  localparam int T_RESTART_US = 64000;
  localparam int T_SSC_ARM_NS = 1000;

  // Cycle counts at the system clock
  localparam int WIN1_CYCLES = T_WIN1_US * CYC_PER_US;
  localparam int WIN2_CYCLES = T_WIN2_US * CYC_PER_US;
  localparam int WIN3_CYCLES = T_WIN3_US * CYC_PER_US;
  localparam int RESTART_CYCLES = T_RESTART_US * CYC_PER_US;
  localparam int SSC_ARM_CYCLES = (T_SSC_ARM_NS * CYC_PER_US + 999) / 1000;

  localparam int CNT_W = 22;
  localparam int SSC_W = 6;
  localparam int STRETCH_DIV = 8;
  localparam int DIV_W = 3;

  // Register word offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_INIT = 12'h004;
  localparam logic [11:0] OFS_OCCFG = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;

  // Field positions
  localparam int CTRL_ON_LSB = 0;
  localparam int CTRL_FAIL_BIT = 8;
  localparam int INIT_IOD_LSB = 0;
  localparam int INIT_BAL_LO_BIT = 8;
  localparam int INIT_BAL_HI_BIT = 9;
  localparam int INIT_THERM_BIT = 12;
  localparam int INIT_TRANS_BIT = 13;
  localparam int CFG_LOWTHR_LSB = 0;
  localparam int CFG_HALF_LSB = 8;
  localparam int CFG_SKIP_LSB = 16;
  localparam int STAT_DRIVE_LSB = 0;
  localparam int STAT_WIN_LSB = 8;
  localparam int STAT_LATCH_LSB = 16;
  localparam int STAT_RETRY_LSB = 24;

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] RST_REG = 32'h0000_0000;

  typedef enum logic [1:0] {
    STAGE_DONE,
    STAGE_ONE,
    STAGE_TWO,
    STAGE_THREE
  } win_stage_t;

  typedef enum logic [1:0] {
    CH_IDLE,
    CH_ON,
    CH_RETRY,
    CH_LATCHED
  } ch_state_t;

endpackage

/* File: logic/oc_window_timer.sv */
// High overcurrent window sequencer for one channel
`timescale 1ns/1ps
`default_nettype none
module oc_window_timer #(
  parameter int unsigned T1 = oc_ctrl_pkg::WIN1_CYCLES,
  parameter int unsigned T2 = oc_ctrl_pkg::WIN2_CYCLES,
  parameter int unsigned T3 = oc_ctrl_pkg::WIN3_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Control
  input  wire logic                   restart,
  input  wire logic                   rerun,
  input  wire logic                   count_en,
  input  wire logic                   half,
  input  wire logic                   slow_two,
  input  wire logic                   skip,
  // Current window
  output var  oc_ctrl_pkg::win_stage_t stage
);

  localparam int CW = oc_ctrl_pkg::CNT_W;
  localparam int DW = oc_ctrl_pkg::DIV_W;

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] lim;
  logic [DW-1:0] pre_r;
  logic          tick;

  // Window length and count tick
  always_comb begin
    case (stage)
      oc_ctrl_pkg::STAGE_ONE: lim = CW'(T1);
      oc_ctrl_pkg::STAGE_TWO: lim = CW'(T2);
      default:                lim = CW'(T3);
    endcase
    if (half) begin
      lim = lim >> 1;
    end
    tick = count_en && (stage != oc_ctrl_pkg::STAGE_DONE) &&
           (!(slow_two && stage == oc_ctrl_pkg::STAGE_TWO) ||
            pre_r == DW'(oc_ctrl_pkg::STRETCH_DIV - 1));
  end

  // Sequence one, two, three, then done
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage <= oc_ctrl_pkg::STAGE_DONE;
      cnt_r <= '0;
      pre_r <= '0;
    end else if (skip) begin
      stage <= oc_ctrl_pkg::STAGE_DONE;
      cnt_r <= '0;
      pre_r <= '0;
    end else if (restart) begin
      stage <= oc_ctrl_pkg::STAGE_ONE;
      cnt_r <= '0;
      pre_r <= '0;
    end else if (rerun) begin
      stage <= oc_ctrl_pkg::STAGE_TWO;
      cnt_r <= '0;
      pre_r <= '0;
    end else if (count_en && stage != oc_ctrl_pkg::STAGE_DONE) begin
      pre_r <= pre_r + 1'b1;
      if (tick) begin
        if (cnt_r >= lim - 1'b1) begin
          cnt_r <= '0;
          pre_r <= '0;
          case (stage)
            oc_ctrl_pkg::STAGE_ONE: stage <= oc_ctrl_pkg::STAGE_TWO;
            oc_ctrl_pkg::STAGE_TWO: stage <= oc_ctrl_pkg::STAGE_THREE;
            default:                stage <= oc_ctrl_pkg::STAGE_DONE;
          endcase
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule // oc_window_timer
`default_nettype wire

/* File: logic/overcurrent_window_control.sv */
// Five-channel overcurrent window control with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module overcurrent_window_control #(
  parameter int unsigned WIN1_CYC    = oc_ctrl_pkg::WIN1_CYCLES,
  parameter int unsigned WIN2_CYC    = oc_ctrl_pkg::WIN2_CYCLES,
  parameter int unsigned WIN3_CYC    = oc_ctrl_pkg::WIN3_CYCLES,
  parameter int unsigned RESTART_CYC = oc_ctrl_pkg::RESTART_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // Global analogue flags, asynchronous
  input  wire logic        supply_low_flag,
  input  wire logic        charge_pump_fail,
  input  wire logic        die_temp_high,
  // Per-channel analogue flags, asynchronous
  input  wire logic [4:0]  high_overcurrent_stage_one,
  input  wire logic [4:0]  high_overcurrent_stage_two,
  input  wire logic [4:0]  high_overcurrent_stage_three,
  input  wire logic [4:0]  low_overcurrent,
  input  wire logic [4:0]  overtemp_shutdown,
  input  wire logic [4:0]  severe_short_detect,
  input  wire logic [4:0]  open_load,
  input  wire logic [4:0]  out_above_half,
  input  wire logic [4:0]  input_pin_toggle,
  // PWM engine, same clock
  input  wire logic [4:0]  pwm_level,
  input  wire logic [4:0]  pwm_full,
  // Drive and threshold controls
  output wire logic [4:0]  channel_drive,
  output wire logic [9:0]  window_stage,
  output wire logic [4:0]  ssc_arm,
  output wire logic [4:0]  low_oc_applied,
  output wire logic [4:0]  low_threshold_low,
  output wire logic [4:0]  ochi_halve,
  output var  logic        high_overcurrent_stage_one_derate
);

  localparam int NCH = oc_ctrl_pkg::NUM_CH;
  localparam int CW = oc_ctrl_pkg::CNT_W;
  localparam int SW = oc_ctrl_pkg::SSC_W;

  // Ballast stretching allowed on a channel for a given selection
  function automatic logic ballast_ok(input logic [1:0] sel,
                                      input int         ch);
    case (sel)
      2'b00:   ballast_ok = 1'b1;
      2'b01:   ballast_ok = (ch == 2);
      2'b10:   ballast_ok = (ch == 2) || (ch == 3);
      default: ballast_ok = 1'b0;
    endcase
  endfunction

  // Synchronised flags
  logic       uv_s;
  logic       cpf_s;
  logic       hot_s;
  logic [4:0] oc1_s;
  logic [4:0] oc2_s;
  logic [4:0] oc3_s;
  logic [4:0] low_overcurrent_s;
  logic [4:0] ots_s;
  logic [4:0] ssc_s;
  logic [4:0] ol_s;
  logic [4:0] half_s;
  logic [4:0] pin_s;

  // Analogue flags pass two flip-flops before use
  sync_2ff #(
    .W (48)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({input_pin_toggle, out_above_half, open_load,
               severe_short_detect, overtemp_shutdown, low_overcurrent,
               high_overcurrent_stage_three, high_overcurrent_stage_two,
               high_overcurrent_stage_one, die_temp_high,
               charge_pump_fail, supply_low_flag}),
    .q       ({pin_s, half_s, ol_s, ssc_s, ots_s, low_overcurrent_s,
               oc3_s, oc2_s, oc1_s, hot_s, cpf_s, uv_s})
  );

  // Register contents
  logic [4:0] on_r;
  logic       fail_r;
  logic       fail_prev_r;
  logic [4:0] iod_r;
  logic [1:0] bal_r;
  logic       therm_r;
  logic       trans_r;
  logic [4:0] lowthr_r;
  logic [4:0] halfwin_r;
  logic [4:0] skip_r;

  // Bus data-phase state
  logic       wr_pend_r;
  logic [9:0] waddr_r;
  logic       ctrl_wr;
  logic       init_wr;
  logic       cfg_wr;
  logic       ap_valid;
  logic       mode_chg;

  // Per-channel status gathered for reads, and inrush bit clears
  wire  [4:0] win_act;
  wire  [4:0] latched;
  wire  [4:0] retrying;
  wire  [4:0] iod_clr;

  // Option bits fall back to defaults in Fail mode
  logic [1:0] bal_eff;
  logic [4:0] lowthr_eff;
  logic [4:0] half_eff;
  logic [4:0] skip_eff;

  always_comb begin
    bal_eff    = fail_r ? 2'b00 : bal_r;
    lowthr_eff = fail_r ? 5'h00 : lowthr_r;
    half_eff   = fail_r ? 5'h00 : halfwin_r;
    skip_eff   = fail_r ? 5'h00 : skip_r;
  end

  // Address phase accepted for whole-word transfers
  assign ap_valid = hsel && hready && htrans[1] && (hsize == oc_ctrl_pkg::HSIZE_WORD);
  assign ctrl_wr  = wr_pend_r && (waddr_r == oc_ctrl_pkg::OFS_CTRL[11:2]);
  assign init_wr  = wr_pend_r && (waddr_r == oc_ctrl_pkg::OFS_INIT[11:2]);
  assign cfg_wr   = wr_pend_r && (waddr_r == oc_ctrl_pkg::OFS_OCCFG[11:2]);
  assign mode_chg = fail_r != fail_prev_r;

  // Capture address phase for the following data phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      waddr_r   <= '0;
    end else begin
      wr_pend_r <= ap_valid && hwrite && (haddr[31:12] == 20'h0_0000);
      waddr_r   <= haddr[11:2];
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data prepared at the address phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata <= oc_ctrl_pkg::RST_REG;
    end else if (ap_valid && !hwrite) begin
      hrdata <= '0;
      if (haddr[31:12] == 20'h0_0000) begin
        case (haddr[11:0])
          oc_ctrl_pkg::OFS_CTRL: begin
            hrdata[oc_ctrl_pkg::CTRL_ON_LSB +: 5]  <= on_r;
            hrdata[oc_ctrl_pkg::CTRL_FAIL_BIT]     <= fail_r;
          end
          oc_ctrl_pkg::OFS_INIT: begin
            hrdata[oc_ctrl_pkg::INIT_IOD_LSB +: 5] <= iod_r;
            hrdata[oc_ctrl_pkg::INIT_BAL_LO_BIT]   <= bal_r[0];
            hrdata[oc_ctrl_pkg::INIT_BAL_HI_BIT]   <= bal_r[1];
            hrdata[oc_ctrl_pkg::INIT_THERM_BIT]    <= therm_r;
            hrdata[oc_ctrl_pkg::INIT_TRANS_BIT]    <= trans_r;
          end
          oc_ctrl_pkg::OFS_OCCFG: begin
            hrdata[oc_ctrl_pkg::CFG_LOWTHR_LSB +: 5] <= lowthr_r;
            hrdata[oc_ctrl_pkg::CFG_HALF_LSB +: 5]   <= halfwin_r;
            hrdata[oc_ctrl_pkg::CFG_SKIP_LSB +: 5]   <= skip_r;
          end
          oc_ctrl_pkg::OFS_STAT: begin
            hrdata[oc_ctrl_pkg::STAT_DRIVE_LSB +: 5] <= channel_drive;
            hrdata[oc_ctrl_pkg::STAT_WIN_LSB +: 5]   <= win_act;
            hrdata[oc_ctrl_pkg::STAT_LATCH_LSB +: 5] <= latched;
            hrdata[oc_ctrl_pkg::STAT_RETRY_LSB +: 5] <= retrying;
          end
          default: hrdata <= '0;
        endcase
      end
    end
  end

  // Control register: on bits and Fail mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      on_r        <= '0;
      fail_r      <= 1'b0;
      fail_prev_r <= 1'b0;
    end else begin
      fail_prev_r <= fail_r;
      if (ctrl_wr) begin
        on_r   <= hwdata[oc_ctrl_pkg::CTRL_ON_LSB +: 5];
        fail_r <= hwdata[oc_ctrl_pkg::CTRL_FAIL_BIT];
      end
    end
  end

  // Initialisation register; hardware clear of inrush bits wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      iod_r   <= '0;
      bal_r   <= '0;
      therm_r <= 1'b0;
      trans_r <= 1'b0;
    end else begin
      if (init_wr) begin
        iod_r   <= hwdata[oc_ctrl_pkg::INIT_IOD_LSB +: 5] & ~iod_clr;
        bal_r   <= {hwdata[oc_ctrl_pkg::INIT_BAL_HI_BIT],
                    hwdata[oc_ctrl_pkg::INIT_BAL_LO_BIT]};
        therm_r <= hwdata[oc_ctrl_pkg::INIT_THERM_BIT];
        trans_r <= hwdata[oc_ctrl_pkg::INIT_TRANS_BIT];
      end else begin
        iod_r <= iod_r & ~iod_clr;
      end
    end
  end

  // Overcurrent option register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lowthr_r  <= '0;
      halfwin_r <= '0;
      skip_r    <= '0;
    end else if (cfg_wr) begin
      lowthr_r  <= hwdata[oc_ctrl_pkg::CFG_LOWTHR_LSB +: 5];
      halfwin_r <= hwdata[oc_ctrl_pkg::CFG_HALF_LSB +: 5];
      skip_r    <= hwdata[oc_ctrl_pkg::CFG_SKIP_LSB +: 5];
    end
  end

  // Global stage one derate when die is hot
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      high_overcurrent_stage_one_derate <= 1'b0;
    end else begin
      high_overcurrent_stage_one_derate <= therm_r && hot_s;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    oc_ctrl_pkg::ch_state_t  st_r;
    oc_ctrl_pkg::ch_state_t  st_nxt;
    oc_ctrl_pkg::win_stage_t stage;
    logic          drive_r;
    logic          drive_nxt;
    logic          pin_prev_r;
    logic          pin_rise;
    logic          restart;
    logic          rerun;
    logic          fault_now;
    logic          latch_kind;
    logic          oc_event;
    logic          in_win;
    logic          iod;
    logic          set_ev;
    logic          rewrite_ev;
    logic          cnt_en;
    logic          slow_two;
    logic          ssc_hit;
    logic [CW-1:0] retry_cnt_r;
    logic [SW-1:0] ssc_cnt_r;
    logic          arm_r;
    logic          low_oc_r;
    logic          low_thr_r;
    logic          halve_r;

    // Fault sources and events
    always_comb begin
      iod        = iod_r[i] && !fail_r;
      in_win     = stage != oc_ctrl_pkg::STAGE_DONE;
      ssc_hit    = ssc_s[i] && (ssc_cnt_r != '0);
      set_ev     = ctrl_wr && hwdata[i] && !on_r[i];
      rewrite_ev = ctrl_wr && hwdata[i] && on_r[i];
      pin_rise   = pin_s[i] && !pin_prev_r;
      oc_event   = oc1_s[i] || oc2_s[i] || oc3_s[i] ||
                   (low_overcurrent_s[i] && !in_win && !iod);
      fault_now  = (st_r == oc_ctrl_pkg::CH_ON) &&
                   (uv_s || oc_event || ots_s[i] || ssc_hit);
      latch_kind = ots_s[i] || ssc_hit || oc1_s[i];
      rerun      = (st_r == oc_ctrl_pkg::CH_ON) && iod && !in_win &&
                   low_overcurrent_s[i] && !fault_now;
      cnt_en     = drive_r && !(uv_s || cpf_s || ots_s[i]);
      slow_two   = ballast_ok(bal_eff, i) && !iod && ol_s[i] &&
                   (fail_r || pwm_full[i]);
    end

    // Channel state: idle, on, autorestart wait, latched off
    always_comb begin
      st_nxt  = st_r;
      restart = 1'b0;
      if (mode_chg) begin
        st_nxt = oc_ctrl_pkg::CH_IDLE;
      end else begin
        case (st_r)
          oc_ctrl_pkg::CH_IDLE: begin
            if (fail_r) begin
              st_nxt = oc_ctrl_pkg::CH_ON;
            end else if (set_ev) begin
              st_nxt  = oc_ctrl_pkg::CH_ON;
              restart = 1'b1;
            end
          end
          oc_ctrl_pkg::CH_ON: begin
            if (fault_now) begin
              st_nxt = (fail_r && !latch_kind) ? oc_ctrl_pkg::CH_RETRY
                                               : oc_ctrl_pkg::CH_LATCHED;
            end else if (!fail_r && !on_r[i]) begin
              st_nxt = oc_ctrl_pkg::CH_IDLE;
            end else if (fail_r && pin_rise) begin
              restart = 1'b1;
            end
          end
          oc_ctrl_pkg::CH_RETRY: begin
            if (retry_cnt_r == CW'(RESTART_CYC - 1)) begin
              st_nxt  = oc_ctrl_pkg::CH_ON;
              restart = 1'b1;
            end
          end
          oc_ctrl_pkg::CH_LATCHED: begin
            if (!fail_r && rewrite_ev) begin
              st_nxt = oc_ctrl_pkg::CH_ON;
            end else if (!fail_r && !on_r[i]) begin
              st_nxt = oc_ctrl_pkg::CH_IDLE;
            end
          end
          default: st_nxt = oc_ctrl_pkg::CH_IDLE;
        endcase
      end
      drive_nxt = (st_nxt == oc_ctrl_pkg::CH_ON) && !fault_now &&
                  (fail_r ? pin_s[i] : pwm_level[i]);
    end

    // State, drive and pin edge history
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        st_r       <= oc_ctrl_pkg::CH_IDLE;
        drive_r    <= 1'b0;
        pin_prev_r <= 1'b0;
      end else begin
        st_r       <= st_nxt;
        drive_r    <= drive_nxt;
        pin_prev_r <= pin_s[i];
      end
    end

    // Autorestart interval counter
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        retry_cnt_r <= '0;
      end else if (st_r != oc_ctrl_pkg::CH_RETRY) begin
        retry_cnt_r <= '0;
      end else begin
        retry_cnt_r <= retry_cnt_r + 1'b1;
      end
    end

    // Short detect armed for a brief span after each turn-on
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        ssc_cnt_r <= '0;
        arm_r     <= 1'b0;
      end else if (drive_nxt && !drive_r) begin
        ssc_cnt_r <= SW'(oc_ctrl_pkg::SSC_ARM_CYCLES);
        arm_r     <= oc_ctrl_pkg::SSC_ARM_CYCLES != 0;
      end else if (ssc_cnt_r != '0) begin
        ssc_cnt_r <= ssc_cnt_r - 1'b1;
        arm_r     <= ssc_cnt_r != SW'(1); // Flag tracks counter from a flop
      end else begin
        arm_r     <= 1'b0;
      end
    end

    // Threshold selections to the analogue comparators
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        low_oc_r  <= 1'b0;
        low_thr_r <= 1'b0;
        halve_r   <= 1'b0;
      end else begin
        low_oc_r  <= (st_r == oc_ctrl_pkg::CH_ON) && !in_win;
        low_thr_r <= lowthr_eff[i];
        halve_r   <= trans_r && in_win && drive_r && !half_s[i];
      end
    end

    oc_window_timer #(
      .T1 (WIN1_CYC),
      .T2 (WIN2_CYC),
      .T3 (WIN3_CYC)
    ) u_timer (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .restart  (restart),
      .rerun    (rerun),
      .count_en (cnt_en),
      .half     (half_eff[i]),
      .slow_two (slow_two),
      .skip     (skip_eff[i]),
      .stage    (stage)
    );

    assign channel_drive[i]       = drive_r;
    assign window_stage[2*i +: 2] = 2'(stage);
    assign ssc_arm[i]             = arm_r;
    assign low_oc_applied[i]      = low_oc_r;
    assign low_threshold_low[i]   = low_thr_r;
    assign ochi_halve[i]          = halve_r;
    assign win_act[i]             = in_win;
    assign latched[i]             = st_r == oc_ctrl_pkg::CH_LATCHED;
    assign retrying[i]            = st_r == oc_ctrl_pkg::CH_RETRY;
    assign iod_clr[i]             = fault_now && oc_event;
  end

endmodule // overcurrent_window_control
`default_nettype wire

/* File: logic/sync_2ff.sv */
// Two-stage synchroniser for asynchronous analogue flags
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Flags
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // sync_2ff
`default_nettype wire
